// File: pkg/dpow_consts.svh
//----------------------------------------------------------------------
//----------------------------------------------------------------------
`ifndef DPOW_CONSTS_SVH
`define DPOW_CONSTS_SVH

// register byte offsets
`define DPOW_ADDR_CMD    8'h00
`define DPOW_ADDR_CFG    8'h04
`define DPOW_ADDR_STAT   8'h08
`define DPOW_ADDR_TLAT   8'h0C

// command register fields
`define DPOW_F_CMD       3:0
`define DPOW_F_BA        6:4
`define DPOW_F_ADDR      21:8

// config register fields and reset
`define DPOW_F_WL        3:0
`define DPOW_F_AL        7:4
`define DPOW_F_WR        12:8
`define DPOW_B_CHOP      16
`define DPOW_CFG_MASK    32'h0001_1FFF
`define DPOW_CFG_RST     32'h0000_0805

// pin encodings {cs, ras, cas, we}, active low
`define DPOW_PIN_NOP     4'h7
`define DPOW_PIN_MRS     4'h0
`define DPOW_PIN_REF     4'h1
`define DPOW_PIN_WR      4'h4
`define DPOW_B_AP        10
`define DPOW_B_BC        12

// edge counts
`define DPOW_WR_CHOP_ADD 8'h02
`define DPOW_WR_BL_ADD   8'h04
`define DPOW_WRA_ADD     8'h01
`define DPOW_REF_PD      8'h01
`define DPOW_ODT_SHORT   8'h04
`define DPOW_ODT_LONG    8'h06
`define DPOW_LVL_STRB    8'h28
`define DPOW_LVL_DQS     8'h19
`define DPOW_MRD         8'h04
`define DPOW_TLAT_SUB    8'h02
`define DPOW_AGE_MAX     8'hFF

`endif

// File: pkg/dpow_pkg.sv
package dpow_pkg;

    // controller commands
    typedef enum logic [3:0] {
        DPOW_NOP    = 4'h0,
        DPOW_MRS    = 4'h1,
        DPOW_REF    = 4'h2,
        DPOW_WR     = 4'h3,
        DPOW_WRA    = 4'h4,
        DPOW_PDE    = 4'h5,
        DPOW_PDX    = 4'h6,
        DPOW_ODTON  = 4'h7,
        DPOW_ODTOFF = 4'h8,
        DPOW_LVLON  = 4'h9,
        DPOW_STROBE = 4'hA,
        DPOW_LVLOFF = 4'hB
    } dpow_cmd_e;

    // link sequencer states, gray along the path
    typedef enum logic [1:0] {
        S_IDLE  = 2'h0,
        S_WAIT  = 2'h1,
        S_ISSUE = 2'h3,
        S_ACK   = 2'h2
    } dpow_state_e;

    // request word handed to the link domain
    typedef struct packed {
        dpow_cmd_e   cmd;
        logic [2:0]  ba;
        logic [13:0] addr;
        logic [3:0]  wl;
        logic [3:0]  al;
        logic [4:0]  wr;
        logic        chopFixed;
    } dpow_req_s;

    // link state reported back
    typedef struct packed {
        logic ack;
        logic lvlFb;
        logic lvl;
        logic odt;
        logic cke;
    } dpow_stat_s;

endpackage : dpow_pkg

// File: src/dpow_sync2.sv
`timescale 1ns/10ps
`default_nettype none

module dpow_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,    // destination clock
    input  wire logic         rst_b,  // async reset, low
    input  wire logic [W-1:0] din,    // foreign signal
    output logic      [W-1:0] dout    // synchronised copy
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // two flops, first one read only by the second
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
        end
    end

    assign dout = sync_r;

endmodule : dpow_sync2

`default_nettype wire

// File: src/dpow_guard_tmr.sv
`timescale 1ns/10ps
`default_nettype none

module dpow_guard_tmr #(
    parameter int W = 8
) (
    input  wire logic         clk,    // link clock
    input  wire logic         rst_b,  // async reset, low
    input  wire logic         ld,     // load request
    input  wire logic [W-1:0] val,    // edges to wait
    output logic      [W-1:0] cnt,    // edges still to wait
    output logic              zero    // wait is over
);

    logic [W-1:0] cnt_r;

    // a load only lengthens a running wait, never shortens it;
    // an equal load restarts the count so the full wait still follows it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= '0;
        end else if (ld && (val >= cnt_r)) begin
            cnt_r <= val;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    assign cnt  = cnt_r;
    assign zero = (cnt_r == '0);

endmodule : dpow_guard_tmr

`default_nettype wire

// File: src/dpow_host.sv
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "dpow_consts.svh"

module dpow_host #(
    parameter int WREC_NS    = 15,     // write recovery time, ns
    parameter int MEMCK_PS   = 48000,  // link clock period, ps
    parameter int MODUPD_CYC = 12      // mode register update delay, edges
) (
    input  wire logic        mclk,         // bus clock
    input  wire logic        rst_b,        // async reset, low
    input  wire logic        memClk,       // link clock
    input  wire logic        psel,         // apb select
    input  wire logic        penable,      // apb enable
    input  wire logic        pwrite,       // apb direction
    input  wire logic [7:0]  paddr,        // apb byte address
    input  wire logic [31:0] pwdata,       // apb write data
    output logic      [31:0] prdata,       // apb read data
    output logic             pready,       // apb ready
    output logic             pslverr,      // apb error
    output logic             memCke,       // clock enable pin
    output logic             memCs_b,      // chip select, low
    output logic             memRas_b,     // row strobe, low
    output logic             memCas_b,     // column strobe, low
    output logic             memWe_b,      // write enable, low
    output logic      [2:0]  memBa,        // bank address
    output logic      [13:0] memAddr,      // address pins
    output logic             memOdt,       // termination control
    output logic             memDqsOut,    // strobe drive level
    output logic             memDqsOe_b,   // strobe enable, low drives
    input  wire logic        memLvlFb      // leveling feedback pin
);

    //------------------------------------------------------------------
    // derived counts
    //------------------------------------------------------------------
    localparam int WREC_RAW = (WREC_NS * 1000 + MEMCK_PS - 1) / MEMCK_PS;
    localparam logic [7:0] WREC_CYC = 8'((WREC_RAW < 1) ? 1 : WREC_RAW);
    localparam logic [7:0] MOD_CYC  = 8'(MODUPD_CYC);

    //------------------------------------------------------------------
    // bus domain
    //------------------------------------------------------------------
    logic [31:0]         prdata_r;
    logic                pready_r;
    logic                pslverr_r;
    logic [31:0]         cfg_r;
    logic                reqTgl_r;
    dpow_pkg::dpow_req_s req_r;
    dpow_pkg::dpow_stat_s statSync;

    // address decode and error terms
    wire setupPh  = psel && !penable;
    wire accessPh = psel && penable && pready_r;
    wire hitCmd   = (paddr == `DPOW_ADDR_CMD);
    wire hitCfg   = (paddr == `DPOW_ADDR_CFG);
    wire hitStat  = (paddr == `DPOW_ADDR_STAT);
    wire hitTlat  = (paddr == `DPOW_ADDR_TLAT);
    wire busy     = (reqTgl_r != statSync.ack);
    wire badAddr  = !(hitCmd || hitCfg || hitStat || hitTlat);
    wire badWr    = pwrite && (hitStat || hitTlat || (hitCmd && busy));
    wire wrOk     = accessPh && pwrite && !pslverr_r;
    wire wrCmd    = wrOk && hitCmd;
    wire wrCfg    = wrOk && hitCfg;

    // read selection; device termination latency shown for reference
    wire [7:0]  tLat    = {4'h0, cfg_r[`DPOW_F_WL]} + {4'h0, cfg_r[`DPOW_F_AL]}
                          - `DPOW_TLAT_SUB;
    wire [31:0] statWrd = {27'h0, statSync.lvlFb, statSync.lvl, statSync.odt,
                           statSync.cke, busy};
    wire [31:0] rdMux   = hitCmd  ? {10'h0, req_r.addr, 1'b0, req_r.ba, req_r.cmd} :
                          hitCfg  ? cfg_r :
                          hitStat ? statWrd :
                          hitTlat ? {24'h0, tLat} : 32'h0;

    // request word built from the command write and the current config
    dpow_pkg::dpow_req_s reqNxt;
    assign reqNxt.cmd       = dpow_pkg::dpow_cmd_e'(pwdata[`DPOW_F_CMD]);
    assign reqNxt.ba        = pwdata[`DPOW_F_BA];
    assign reqNxt.addr      = pwdata[`DPOW_F_ADDR];
    assign reqNxt.wl        = cfg_r[`DPOW_F_WL];
    assign reqNxt.al        = cfg_r[`DPOW_F_AL];
    assign reqNxt.wr        = cfg_r[`DPOW_F_WR];
    assign reqNxt.chopFixed = cfg_r[`DPOW_B_CHOP];

    // apb answer: zero wait, ready in the access cycle
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
        end else begin
            pready_r  <= setupPh;
            pslverr_r <= setupPh && (badAddr || badWr);
            prdata_r  <= (setupPh && !pwrite) ? rdMux : 32'h0;
        end
    end

    // software registers and request toggle
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_r    <= `DPOW_CFG_RST;
            req_r    <= '0;
            reqTgl_r <= 1'b0;
        end else begin
            if (wrCfg) begin
                cfg_r <= pwdata & `DPOW_CFG_MASK;
            end
            if (wrCmd) begin
                req_r    <= reqNxt;
                reqTgl_r <= !reqTgl_r;
            end
        end
    end

    //------------------------------------------------------------------
    // crossings
    //------------------------------------------------------------------
    logic               linkRstM_r;
    logic               linkRst_b;
    logic               reqSync;
    logic               ackTgl_r;
    logic               cke_r;
    logic               odt_r;
    logic               lvl_r;
    dpow_pkg::dpow_stat_s statLink;

    // reset release synchronised to the link clock
    always_ff @(posedge memClk or negedge rst_b) begin
        if (!rst_b) begin
            linkRstM_r <= 1'b0;
            linkRst_b  <= 1'b0;
        end else begin
            linkRstM_r <= 1'b1;
            linkRst_b  <= linkRstM_r;
        end
    end

    assign statLink = '{ack: ackTgl_r, lvlFb: memLvlFb, lvl: lvl_r,
                        odt: odt_r, cke: cke_r};

    dpow_sync2 #(.W(5)) uSyncStat (
        .clk   (mclk),
        .rst_b (rst_b),
        .din   (statLink),
        .dout  (statSync)
    );

    dpow_sync2 #(.W(1)) uSyncReq (
        .clk   (memClk),
        .rst_b (linkRst_b),
        .din   (reqTgl_r),
        .dout  (reqSync)
    );

    //------------------------------------------------------------------
    // link domain sequencer
    //------------------------------------------------------------------
    dpow_pkg::dpow_state_e st_r;
    dpow_pkg::dpow_state_e st_nxt;
    dpow_pkg::dpow_req_s   lreq_r;
    logic                  reqSeen_r;
    logic [3:0]            pinCmd_r;
    logic [2:0]            ba_r;
    logic [13:0]           addr_r;
    logic                  dqsOut_r;
    logic                  dqsOe_b_r;
    logic [7:0]            pdCnt;
    logic [7:0]            odtCnt;
    logic [7:0]            mrdCnt;
    logic [7:0]            dqsCnt;
    logic [7:0]            strbCnt;
    logic                  pdZero;
    logic                  odtZero;
    logic                  mrdZero;
    logic                  dqsZero;
    logic                  strbZero;

    // command class decode
    wire reqNew  = (reqSync != reqSeen_r);
    wire isMrs   = (lreq_r.cmd == dpow_pkg::DPOW_MRS) ||
                   (lreq_r.cmd == dpow_pkg::DPOW_LVLON) ||
                   (lreq_r.cmd == dpow_pkg::DPOW_LVLOFF);
    wire isWr    = (lreq_r.cmd == dpow_pkg::DPOW_WR);
    wire isWra   = (lreq_r.cmd == dpow_pkg::DPOW_WRA);
    wire isRef   = (lreq_r.cmd == dpow_pkg::DPOW_REF);
    wire isBl8   = !lreq_r.chopFixed && lreq_r.addr[`DPOW_B_BC];
    wire go      = (lreq_r.cmd == dpow_pkg::DPOW_PDE)    ? pdZero :
                   (lreq_r.cmd == dpow_pkg::DPOW_ODTOFF) ? odtZero :
                   (lreq_r.cmd == dpow_pkg::DPOW_STROBE) ?
                       (lvl_r && strbZero && !dqsOe_b_r) :
                   isMrs ? mrdZero : 1'b1;
    wire fire    = (st_r == dpow_pkg::S_WAIT) && go;

    // power-down guard loads
    wire [7:0] wl8    = {4'h0, lreq_r.wl};
    wire [7:0] wrBase = lreq_r.chopFixed ? wl8 + `DPOW_WR_CHOP_ADD
                                         : wl8 + `DPOW_WR_BL_ADD;
    wire [7:0] pdVal  = isWr  ? wrBase + WREC_CYC :
                        isWra ? wrBase + {3'h0, lreq_r.wr} + `DPOW_WRA_ADD :
                        isRef ? `DPOW_REF_PD : MOD_CYC;
    wire       pdLd   = fire && (isWr || isWra || isRef || isMrs);

    // termination hold and leveling guard loads
    wire       odtLd  = fire && ((lreq_r.cmd == dpow_pkg::DPOW_ODTON) ||
                                 ((isWr || isWra) && odt_r));
    wire [7:0] odtVal = ((isWr || isWra) && isBl8) ? `DPOW_ODT_LONG
                                                   : `DPOW_ODT_SHORT;
    wire       lvlLd  = fire && (lreq_r.cmd == dpow_pkg::DPOW_LVLON);

    // pin encoding for the command being issued; the autoprecharge bit
    // follows the write kind so a plain write never looks like one with it
    wire [3:0]  pinNxt  = isMrs ? `DPOW_PIN_MRS :
                          isRef ? `DPOW_PIN_REF :
                          (isWr || isWra) ? `DPOW_PIN_WR : `DPOW_PIN_NOP;
    wire [13:0] addrNxt = isWra ? (lreq_r.addr | (14'h1 << `DPOW_B_AP)) :
                          isWr  ? (lreq_r.addr & ~(14'h1 << `DPOW_B_AP)) :
                                  lreq_r.addr;

    // next state
    assign st_nxt = (st_r == dpow_pkg::S_IDLE)  ? (reqNew ? dpow_pkg::S_WAIT
                                                          : dpow_pkg::S_IDLE) :
                    (st_r == dpow_pkg::S_WAIT)  ? (go ? dpow_pkg::S_ISSUE
                                                      : dpow_pkg::S_WAIT) :
                    (st_r == dpow_pkg::S_ISSUE) ? dpow_pkg::S_ACK : dpow_pkg::S_IDLE;

    dpow_guard_tmr #(.W(8)) uPdTmr (
        .clk(memClk), .rst_b(linkRst_b), .ld(pdLd), .val(pdVal),
        .cnt(pdCnt), .zero(pdZero)
    );
    dpow_guard_tmr #(.W(8)) uOdtTmr (
        .clk(memClk), .rst_b(linkRst_b), .ld(odtLd), .val(odtVal),
        .cnt(odtCnt), .zero(odtZero)
    );
    dpow_guard_tmr #(.W(8)) uMrdTmr (
        .clk(memClk), .rst_b(linkRst_b), .ld(fire && isMrs), .val(`DPOW_MRD),
        .cnt(mrdCnt), .zero(mrdZero)
    );
    dpow_guard_tmr #(.W(8)) uDqsTmr (
        .clk(memClk), .rst_b(linkRst_b), .ld(lvlLd), .val(`DPOW_LVL_DQS),
        .cnt(dqsCnt), .zero(dqsZero)
    );
    dpow_guard_tmr #(.W(8)) uStrbTmr (
        .clk(memClk), .rst_b(linkRst_b), .ld(lvlLd), .val(`DPOW_LVL_STRB),
        .cnt(strbCnt), .zero(strbZero)
    );

    // state, request capture and acknowledge
    always_ff @(posedge memClk or negedge linkRst_b) begin
        if (!linkRst_b) begin
            st_r      <= dpow_pkg::S_IDLE;
            lreq_r    <= '0;
            reqSeen_r <= 1'b0;
            ackTgl_r  <= 1'b0;
        end else begin
            st_r <= st_nxt;
            if ((st_r == dpow_pkg::S_IDLE) && reqNew) begin
                lreq_r    <= req_r;
                reqSeen_r <= reqSync;
            end
            if (st_r == dpow_pkg::S_ACK) begin
                ackTgl_r <= reqSeen_r;
            end
        end
    end

    // command pins, one issue cycle then idle
    always_ff @(posedge memClk or negedge linkRst_b) begin
        if (!linkRst_b) begin
            pinCmd_r <= `DPOW_PIN_NOP;
            ba_r     <= 3'h0;
            addr_r   <= 14'h0;
        end else begin
            pinCmd_r <= fire ? pinNxt : `DPOW_PIN_NOP;
            if (fire) begin
                ba_r   <= lreq_r.ba;
                addr_r <= addrNxt;
            end
        end
    end

    // power-down, termination and leveling levels
    always_ff @(posedge memClk or negedge linkRst_b) begin
        if (!linkRst_b) begin
            cke_r <= 1'b0;
            odt_r <= 1'b0;
            lvl_r <= 1'b0;
        end else if (fire) begin
            cke_r <= (lreq_r.cmd == dpow_pkg::DPOW_PDE) ? 1'b0 :
                     (lreq_r.cmd == dpow_pkg::DPOW_PDX) ? 1'b1 : cke_r;
            odt_r <= (lreq_r.cmd == dpow_pkg::DPOW_ODTON)  ? 1'b1 :
                     (lreq_r.cmd == dpow_pkg::DPOW_ODTOFF) ? 1'b0 : odt_r;
            lvl_r <= (lreq_r.cmd == dpow_pkg::DPOW_LVLON)  ? 1'b1 :
                     (lreq_r.cmd == dpow_pkg::DPOW_LVLOFF) ? 1'b0 : lvl_r;
        end
    end

    // strobe drive once leveling has settled, one-cycle rising pulses
    always_ff @(posedge memClk or negedge linkRst_b) begin
        if (!linkRst_b) begin
            dqsOe_b_r <= 1'b1;
            dqsOut_r  <= 1'b0;
        end else begin
            dqsOe_b_r <= !(lvl_r && dqsZero);
            dqsOut_r  <= fire && (lreq_r.cmd == dpow_pkg::DPOW_STROBE);
        end
    end

    assign prdata     = prdata_r;
    assign pready     = pready_r;
    assign pslverr    = pslverr_r;
    assign memCke     = cke_r;
    assign memCs_b    = pinCmd_r[3];
    assign memRas_b   = pinCmd_r[2];
    assign memCas_b   = pinCmd_r[1];
    assign memWe_b    = pinCmd_r[0];
    assign memBa      = ba_r;
    assign memAddr    = addr_r;
    assign memOdt     = odt_r;
    assign memDqsOut  = dqsOut_r;
    assign memDqsOe_b = dqsOe_b_r;

    //------------------------------------------------------------------
    // checks
    //------------------------------------------------------------------
    logic [7:0] lvlAge_r;

    // edges since leveling was enabled, saturating
    always_ff @(posedge memClk or negedge linkRst_b) begin
        if (!linkRst_b) begin
            lvlAge_r <= 8'h0;
        end else if (lvlLd) begin
            lvlAge_r <= 8'h0;
        end else if (lvlAge_r != `DPOW_AGE_MAX) begin
            lvlAge_r <= lvlAge_r + 8'h1;
        end
    end

    wraPdGap_a: assert property (@(posedge memClk) disable iff (!linkRst_b)
        (fire && isWra) |=> (pdCnt >= $past(wrBase) + {3'h0, lreq_r.wr} + 8'h1))
        else $error("autoprecharge power-down guard too short");
    wrChopGap_a: assert property (@(posedge memClk) disable iff (!linkRst_b)
        (fire && isWr && lreq_r.chopFixed) |=> (pdCnt >= wl8 + 8'h2 + WREC_CYC))
        else $error("chop4 write power-down guard too short");
    wrBurstGap_a: assert property (@(posedge memClk) disable iff (!linkRst_b)
        (fire && isWr && !lreq_r.chopFixed) |=> (pdCnt >= wl8 + 8'h4 + WREC_CYC))
        else $error("burst write power-down guard too short");
    refPdGap_a: assert property (@(posedge memClk) disable iff (!linkRst_b)
        (fire && isRef) |=> !pdZero ##1 cke_r == $past(cke_r))
        else $error("power-down too soon after refresh");
    mrsPdGap_a: assert property (@(posedge memClk) disable iff (!linkRst_b)
        (fire && isMrs) |=> (pdCnt >= MOD_CYC))
        else $error("power-down guard after mode set too short");
    ckeFall_a: assert property (@(posedge memClk) disable iff (!linkRst_b)
        $fell(cke_r) |-> $past(pdZero))
        else $error("clock enable dropped while guard ran");
    odtShort_a: assert property (@(posedge memClk) disable iff (!linkRst_b)
        $rose(odt_r) |-> odt_r[*4])
        else $error("termination high under four edges");
    odtLong_a: assert property (@(posedge memClk) disable iff (!linkRst_b)
        (fire && (isWr || isWra) && isBl8 && odt_r) |=> odt_r[*6])
        else $error("termination high under six edges after burst write");
    strobeFirst_a: assert property (@(posedge memClk) disable iff (!linkRst_b)
        $rose(dqsOut_r) |-> (lvlAge_r >= 8'd40) && lvl_r)
        else $error("strobe edge before forty edges");
    strobeDrive_a: assert property (@(posedge memClk) disable iff (!linkRst_b)
        $fell(dqsOe_b_r) |-> (lvlAge_r >= 8'd25))
        else $error("strobe driven before twenty-five edges");
    mrsSpacing_a: assert property (@(posedge memClk) disable iff (!linkRst_b)
        (fire && isMrs) |=> !(fire && isMrs)[*3])
        else $error("mode sets closer than four edges");

endmodule : dpow_host

`default_nettype wire

// File: tb/dpow_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
// behavioural device: checks controller spacing, counts violations
module dpow_dev_model #(
    parameter int MODE_REGISTER_UPDATE_DELAY = 12,  // mode register update delay, edges
    parameter int WRC  = 1    // write recovery, ns over period rounded up
) (
    input  wire logic        memClk,   // link clock
    input  wire logic        rst_b,    // async reset, low
    input  wire logic        cke,      // clock enable pin
    input  wire logic [3:0]  pins,     // cs, ras, cas, we
    input  wire logic [1:0]  a12a10,   // burst and autoprecharge bits
    input  wire logic        odt,      // termination pin
    input  wire logic        dqs,      // strobe level
    input  wire logic        dqsOe_b,  // strobe enable, low drives
    input  wire logic [31:0] cfg,      // timing settings of the bench
    output logic             lvlFb,    // leveling feedback
    output logic             rttOn,    // termination active
    output logic      [31:0] viol      // spacing violations seen
);
    logic [7:0]  aW, aR, aM, oH;
    logic        wra, bl8w, ckeQ, odtQ, dqsQ, oeQ;
    logic [15:0] sh;
    wire         isWr  = pins == 4'h4;
    wire         isMrs = pins == 4'h0;
    wire         isRef = pins == 4'h1;
    wire         pde   = ckeQ && !cke;
    wire  [7:0]  need  = 8'(cfg[3:0]) + (cfg[16] ? 8'h02 : 8'h04)
                       + (wra ? 8'(cfg[12:8]) + 8'h01 : 8'(WRC));
    // termination follows the pin after the write-plus-additive latency less two edges
    assign rttOn = sh[4'(cfg[3:0] + cfg[7:4] - 4'h3)];
    // ages count real clock edges since each command
    always_ff @(posedge memClk or negedge rst_b) begin
        if (!rst_b) begin
            {aW, aR, aM, oH} <= {4{8'hFF}};
            {wra, bl8w, ckeQ, odtQ, dqsQ, oeQ, lvlFb} <= 7'h02;
            sh   <= 16'h0;
            viol <= 32'h0;
        end else begin
            aW <= isWr ? 8'h01 : aW + 8'(aW != 8'hFF);
            aR <= isRef ? 8'h01 : aR + 8'(aR != 8'hFF);
            aM <= isMrs ? 8'h01 : aM + 8'(aM != 8'hFF);
            oH <= odt ? (odtQ ? oH + 8'(oH != 8'hFF) : 8'h01) : 8'h00;
            wra  <= isWr ? a12a10[0] : wra;
            bl8w <= odt && (bl8w || (isWr && a12a10[1] && !cfg[16]));
            {ckeQ, odtQ, dqsQ, oeQ} <= {cke, odt, dqs, dqsOe_b};
            sh    <= {sh[14:0], odt};
            lvlFb <= lvlFb ^ (dqs && !dqsQ);
            viol  <= viol + 32'(pde && aW < need)
                   + 32'(pde && aR < 8'h01)
                   + 32'(pde && aM < 8'(MODE_REGISTER_UPDATE_DELAY))
                   + 32'(isMrs && aM < 8'h04)
                   + 32'(odtQ && !odt && oH < (bl8w ? 8'h06 : 8'h04))
                   + 32'(oeQ && !dqsOe_b && aM < 8'h19)
                   + 32'(!dqsQ && dqs && aM < 8'h28);
        end
    end
endmodule : dpow_dev_model
`default_nettype wire

// File: tb/ddr3_pd_odt_wlvl_timing_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "dpow_consts.svh"
module ddr3_pd_odt_wlvl_timing_tb;
    logic        mclk = 0, memClk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, viol, cfg = `DPOW_CFG_RST;
    logic        pready, pslverr, err, cke, csb, rasb, casb, web, odt, dqs, oeb, fb;
    logic [2:0]  ba;
    logic [13:0] addr, a;
    logic [3:0]  e = 4'h0;
    int          miscompares = 0, compares = 0, cyc = 0;
    localparam logic [3:0] SEQ [24] = '{0, 1, 1, 5, 6, 3, 5, 6, 4, 5, 6, 2, 5, 6,
                                        7, 3, 8, 7, 8, 9, 10, 10, 11, 0};
    // clocks with unrelated phase
    initial forever #20 mclk = ~mclk;
    initial begin #7; forever #24 memClk = ~memClk; end
    dpow_host DUT (.mclk(mclk), .rst_b(rst_b), .memClk(memClk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .memCke(cke),
        .memCs_b(csb), .memRas_b(rasb), .memCas_b(casb), .memWe_b(web), .memBa(ba),
        .memAddr(addr), .memOdt(odt), .memDqsOut(dqs), .memDqsOe_b(oeb), .memLvlFb(fb));
    dpow_dev_model MEM (.memClk(memClk), .rst_b(rst_b), .cke(cke),
        .pins({csb, rasb, casb, web}), .a12a10({addr[12], addr[10]}), .odt(odt),
        .dqs(dqs), .dqsOe_b(oeb), .cfg(cfg), .lvlFb(fb), .rttOn(), .viol(viol));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, d};
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    // issue one command, optionally try a second while busy, then poll
    task cmd(input logic [3:0] c, input logic dbl);
        a = 14'($urandom);
        apb(1'b1, `DPOW_ADDR_CMD, {10'h0, a, 4'h0, c});
        chk(32'(err), 32'h0);
        if (dbl) begin
            apb(1'b1, `DPOW_ADDR_CMD, 32'h0);
            chk(32'(err), 32'h1);
        end
        rd = 32'h1;
        repeat (300) if (rd[0] !== 1'b0) apb(1'b0, `DPOW_ADDR_STAT, 32'h0);
        if (c == 5 || c == 6) e[0] = c[1];
        if (c == 7 || c == 8) e[1] = c[0];
        if (c == 9 || c == 11) e[2] = !c[1];
        if (c == 10) e[3] = !e[3];
        chk(32'(rd[4:0]), {27'h0, e, 1'b0});
        apb(1'b0, `DPOW_ADDR_CMD, 32'h0);
        chk(rd, {10'h0, a, 4'h0, c});
    endtask : cmd
    task results;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results
    // timeout on a hang
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            miscompares++;
            results();
        end
    end
    // main sequence
    initial begin
        void'($urandom(31));
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
        apb(1'b0, `DPOW_ADDR_CFG, 32'h0);
        chk(rd, 32'h0000_0805);
        apb(1'b0, 8'h10, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b1, `DPOW_ADDR_STAT, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b1, 8'h06, 32'h0);
        chk(32'(err), 32'h1);
        for (int k = 0; k < 6; k++) begin
            cfg = {15'h0, k[0], 3'h0, 5'(5 + $urandom % 12), 4'($urandom % 3),
                   4'(5 + $urandom % 5)};
            apb(1'b1, `DPOW_ADDR_CFG, cfg);
            apb(1'b0, `DPOW_ADDR_CFG, 32'h0);
            chk(rd, cfg);
            apb(1'b0, `DPOW_ADDR_TLAT, 32'h0);
            chk(32'(rd[7:0]), 32'(cfg[3:0]) + 32'(cfg[7:4]) - 32'h2);
            if (k == 0) cmd(4'h6, 1'b0);
            for (int i = 0; i < 24; i++) cmd(SEQ[i], 1'(i == 9));
        end
        chk(viol, 32'h0);
        results();
    end
endmodule : ddr3_pd_odt_wlvl_timing_tb
`default_nettype wire
